// ==== hw/uhtx_pkg.sv ====
package uhtx_pkg;
  // ==========================================================
  // Register map: printed offsets are word indices
  // ==========================================================
  localparam int          ADDR_W          = 12;
  localparam logic [9:0]  IDX_MAX_PKT     = 10'h110;
  localparam logic [9:0]  IDX_CTRL_LOW    = 10'h112;
  localparam logic [9:0]  IDX_CTRL_HIGH   = 10'h113;
  localparam logic [9:0]  IDX_LOAD_COUNT  = 10'h114;

  // ==========================================================
  // Upper control byte fields
  // ==========================================================
  localparam int          BIT_AUTO_READY  = 7;
  localparam int          BIT_RESERVED    = 6;
  localparam int          BIT_MODE_TX     = 5;
  localparam int          BIT_DMA_EN      = 4;
  localparam int          BIT_FORCE_TOG   = 3;
  localparam int          BIT_DMA_MODE    = 2;
  localparam int          BIT_TOG_WE      = 1;
  localparam int          BIT_TOGGLE      = 0;
  localparam logic [7:0]  CTRL_HIGH_RESET = 8'h00;

  // ==========================================================
  // Lower control byte and packet size
  // ==========================================================
  localparam int          BIT_PKT_READY   = 0;
  localparam int          MPS_W           = 11;
  localparam logic [10:0] MPS_RESET       = 11'h040;
  localparam logic [10:0] COUNT_ZERO      = 11'h000;
  localparam logic [10:0] COUNT_ONE       = 11'h001;
endpackage : uhtx_pkg

// ==== hw/uhtx_ctrl_high.sv ====
`timescale 1ns/1ps
// Behaviour
// - With auto ready set, a full max-size load sets packet ready itself.
// - Bit 6 is reserved, read-only, and reads zero.
// - Direction bit: zero selects receive, one selects transmit.
// - Direction bit acts only on an endpoint with a shared FIFO.
// - DMA request enable bit gates the endpoint's DMA requests.
// - Writing force toggle flips data toggle unless toggle write enable is also set, and discards the FIFO packet.
// - DMA mode: zero interrupts per packet, one at transfer end.
// - Toggle bit writes take effect only with toggle write enable high.
// - Toggle write enable clears itself once the toggle is written.
// - Reading the toggle bit returns the present data toggle.
// - Every upper control bit resets to zero.
// - The upper control register is one byte, beside the low byte.
// - Software sets packet ready; hardware clears it after transmission.
module uhtx_ctrl_high (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [uhtx_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic [31:0]                     prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire logic                       fifo_load,
  input  wire logic                       fifo_shared,
  input  wire logic                       fifo_has_room,
  input  wire logic                       pkt_sent,
  input  wire logic                       link_toggle_adv,
  input  wire logic                       dma_pkt_done,
  input  wire logic                       dma_xfer_done,
  output logic                            tx_packet_ready,
  output logic                            dir_is_tx,
  output logic                            dma_req,
  output logic                            dma_irq,
  output logic                            fifo_discard,
  output logic                            data_toggle
);
  import uhtx_pkg::*;

  // ==========================================================
  // Bus decode
  // ==========================================================
  logic [31:0]      prdata_reg;
  logic [31:0]      prdata_next;
  logic             pslverr_reg;
  logic             auto_ready_reg;
  logic             mode_tx_reg;
  logic             dma_en_reg;
  logic             dma_mode_reg;
  logic             toggle_reg;
  logic             toggle_next;
  logic             pkt_ready_reg;
  logic             pkt_ready_next;
  logic [MPS_W-1:0] mps_reg;
  logic [MPS_W-1:0] count_reg;
  logic [MPS_W-1:0] count_next;
  logic             discard_reg;
  logic             irq_reg;

  wire [9:0] word_idx   = paddr[ADDR_W-1:2];
  wire       hit_mps    = (word_idx == IDX_MAX_PKT);
  wire       hit_low    = (word_idx == IDX_CTRL_LOW);
  wire       hit_high   = (word_idx == IDX_CTRL_HIGH);
  wire       hit_count  = (word_idx == IDX_LOAD_COUNT);
  wire       hit_any    = hit_mps | hit_low | hit_high | hit_count;
  wire       setup      = psel & ~penable;
  wire       wr_commit  = psel & penable & pwrite;
  wire       wr_high    = wr_commit & hit_high;
  wire       wr_low     = wr_commit & hit_low;
  wire       wr_mps     = wr_commit & hit_mps;

  // Write side effects of the upper and lower bytes
  wire       force_tog  = wr_high & pwdata[BIT_FORCE_TOG];
  wire       tog_write  = wr_high & pwdata[BIT_TOG_WE];
  wire       sw_ready   = wr_low & pwdata[BIT_PKT_READY];

  // Auto ready fires on the load that completes a max-size packet
  wire       load_full  = fifo_load & ((count_reg + COUNT_ONE) == mps_reg);
  wire       auto_set   = auto_ready_reg & load_full;

  // Write enable and force are strobes: they never read back as one
  wire [7:0] high_byte  = {auto_ready_reg,
                           1'b0,
                           mode_tx_reg,
                           dma_en_reg,
                           1'b0,
                           dma_mode_reg,
                           1'b0,
                           toggle_reg};

  assign prdata_next = hit_high  ? {24'h000000, high_byte} :
                       hit_low   ? {31'h00000000, pkt_ready_reg} :
                       hit_mps   ? {21'h000000, mps_reg} :
                       hit_count ? {21'h000000, count_reg} :
                       32'h00000000;

  // Read data is captured in the setup cycle, so no wait state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg  <= pwrite ? 32'h00000000 : prdata_next;
      pslverr_reg <= ~hit_any;
    end
  end

  assign prdata  = prdata_reg;
  assign pready  = 1'b1;
  assign pslverr = pslverr_reg & psel & penable;

  // ==========================================================
  // Upper control byte storage
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      auto_ready_reg <= CTRL_HIGH_RESET[BIT_AUTO_READY];
      mode_tx_reg    <= CTRL_HIGH_RESET[BIT_MODE_TX];
      dma_en_reg     <= CTRL_HIGH_RESET[BIT_DMA_EN];
      dma_mode_reg   <= CTRL_HIGH_RESET[BIT_DMA_MODE];
    end else if (wr_high) begin
      auto_ready_reg <= pwdata[BIT_AUTO_READY];
      mode_tx_reg    <= pwdata[BIT_MODE_TX];
      dma_en_reg     <= pwdata[BIT_DMA_EN];
      dma_mode_reg   <= pwdata[BIT_DMA_MODE];
    end
  end

  // ==========================================================
  // Data toggle
  // ==========================================================
  // A guarded write beats a force, which beats the link's own advance
  assign toggle_next = tog_write       ? pwdata[BIT_TOGGLE] :
                       force_tog       ? ~toggle_reg :
                       link_toggle_adv ? ~toggle_reg :
                       toggle_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      toggle_reg <= CTRL_HIGH_RESET[BIT_TOGGLE];
    end else begin
      toggle_reg <= toggle_next;
    end
  end

  // ==========================================================
  // Packet ready and load counter
  // ==========================================================
  // A set in the same cycle as the sent pulse wins, so no packet is lost
  assign pkt_ready_next = (sw_ready | auto_set) ? 1'b1 :
                          (pkt_sent | force_tog) ? 1'b0 :
                          pkt_ready_reg;

  assign count_next = (force_tog | auto_set | sw_ready) ? COUNT_ZERO :
                      fifo_load ? count_reg + COUNT_ONE :
                      count_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pkt_ready_reg <= 1'b0;
      count_reg     <= COUNT_ZERO;
      mps_reg       <= MPS_RESET;
    end else begin
      pkt_ready_reg <= pkt_ready_next;
      count_reg     <= count_next;
      if (wr_mps) begin
        mps_reg <= pwdata[MPS_W-1:0];
      end
    end
  end

  // ==========================================================
  // Endpoint outputs
  // ==========================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      discard_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end else begin
      discard_reg <= force_tog;
      irq_reg     <= dma_en_reg & (dma_mode_reg ? dma_xfer_done
                                                : dma_pkt_done);
    end
  end

  assign tx_packet_ready = pkt_ready_reg;
  assign dir_is_tx       = fifo_shared ? mode_tx_reg : 1'b1;
  // Requests stop while a packet waits, so DMA cannot overfill the FIFO
  assign dma_req         = dma_en_reg & fifo_has_room & ~pkt_ready_reg;
  assign dma_irq         = irq_reg;
  assign fifo_discard    = discard_reg;
  assign data_toggle     = toggle_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  AST_AUTO_SET: assert property (@(posedge pclk) disable iff (!presetn)
    (auto_ready_reg && fifo_load && (count_reg + COUNT_ONE) == mps_reg)
      |=> tx_packet_ready)
    else $error("Auto ready did not set packet ready");

  AST_NO_AUTO: assert property (@(posedge pclk) disable iff (!presetn)
    (!auto_ready_reg && !sw_ready && !tx_packet_ready) |=> !tx_packet_ready)
    else $error("Packet ready set without software or auto");

  AST_RESERVED: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_high) |=> !prdata[BIT_RESERVED])
    else $error("Reserved bit read as one");

  AST_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    fifo_shared |-> (dir_is_tx == mode_tx_reg))
    else $error("Direction does not follow mode bit");

  AST_DIR_DEDIC: assert property (@(posedge pclk)
    disable iff (!presetn) !fifo_shared |-> dir_is_tx)
    else $error("Mode bit acted on a dedicated FIFO");

  AST_DMA_GATE: assert property (@(posedge pclk) disable iff (!presetn)
    !dma_en_reg |-> !dma_req)
    else $error("DMA request while disabled");

  // A full load in the same cycle keeps its packet: the set wins
  AST_FORCE: assert property (@(posedge pclk) disable iff (!presetn)
    (force_tog && !tog_write && !auto_set)
      |=> (data_toggle != $past(data_toggle))
      && fifo_discard && !tx_packet_ready)
    else $error("Force toggle did not flip and discard");

  AST_IRQ_MODE: assert property (@(posedge pclk) disable iff (!presetn)
    (dma_en_reg && dma_mode_reg && dma_pkt_done && !dma_xfer_done)
      |=> !dma_irq)
    else $error("Per-packet interrupt in whole-transfer mode");

  AST_TOG_GUARD: assert property (@(posedge pclk)
    disable iff (!presetn)
      (wr_high && !pwdata[BIT_TOG_WE] && !force_tog && !link_toggle_adv)
      |=> $stable(data_toggle))
    else $error("Toggle changed without write enable");

  AST_TOG_WE_CLR: assert property (@(posedge pclk)
    disable iff (!presetn) tog_write
      |=> ##1 (!psel || !hit_high || pwrite || !prdata[BIT_TOG_WE]))
    else $error("Toggle write enable did not clear");

  AST_TOG_READ: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && hit_high) |=> prdata[BIT_TOGGLE] == $past(toggle_reg))
    else $error("Toggle read back wrong");

  AST_SENT_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    (pkt_sent && !sw_ready && !auto_set) |=> !tx_packet_ready)
    else $error("Packet ready not cleared after transmit");

  // ==========================================================
  // Storage, bus answers and reset values
  // ==========================================================
  // No disable here: the check must run on the release edge itself
  AST_RESET_VAL: assert property (@(posedge pclk)
    $rose(presetn) |-> (high_byte == CTRL_HIGH_RESET && !tx_packet_ready
      && !data_toggle && !dma_irq && !fifo_discard && mps_reg == MPS_RESET
      && count_reg == COUNT_ZERO))
    else $error("Control state not at reset values after release");

  AST_HIGH_STORE: assert property (@(posedge pclk)
    disable iff (!presetn) wr_high |=>
      (auto_ready_reg == $past(pwdata[BIT_AUTO_READY]))
      && (mode_tx_reg == $past(pwdata[BIT_MODE_TX]))
      && (dma_en_reg == $past(pwdata[BIT_DMA_EN]))
      && (dma_mode_reg == $past(pwdata[BIT_DMA_MODE])))
    else $error("Upper byte write did not store");

  AST_MPS_STORE: assert property (@(posedge pclk)
    disable iff (!presetn) wr_mps |=> mps_reg == $past(pwdata[MPS_W-1:0]))
    else $error("Max packet size write did not store");

  AST_COUNT_CLR: assert property (@(posedge pclk)
    disable iff (!presetn) auto_set |=> count_reg == COUNT_ZERO)
    else $error("Load count not restarted after auto ready");

  // A load short of the size must leave the flag to software
  AST_SHORT_LOAD: assert property (@(posedge pclk)
    disable iff (!presetn) (fifo_load && !load_full && !sw_ready
      && !tx_packet_ready) |=> !tx_packet_ready)
    else $error("Packet ready set before a full packet was loaded");

  AST_SW_SET: assert property (@(posedge pclk)
    disable iff (!presetn) sw_ready |=> tx_packet_ready)
    else $error("Software set of packet ready was lost");

  AST_DMA_REQ: assert property (@(posedge pclk)
    disable iff (!presetn)
      (dma_en_reg && fifo_has_room && !tx_packet_ready) |-> dma_req)
    else $error("DMA request missing while enabled with room");

  AST_DMA_HOLD: assert property (@(posedge pclk)
    disable iff (!presetn) tx_packet_ready |-> !dma_req)
    else $error("DMA request while a packet waits");

  AST_IRQ_PKT: assert property (@(posedge pclk)
    disable iff (!presetn)
      (dma_en_reg && !dma_mode_reg && dma_pkt_done) |=> dma_irq)
    else $error("Per-packet interrupt missing");

  AST_IRQ_XFER: assert property (@(posedge pclk)
    disable iff (!presetn)
      (dma_en_reg && dma_mode_reg && dma_xfer_done) |=> dma_irq)
    else $error("Transfer-end interrupt missing");

  AST_IRQ_OFF: assert property (@(posedge pclk)
    disable iff (!presetn) !dma_en_reg |=> !dma_irq)
    else $error("DMA interrupt while requests disabled");

  AST_DISCARD_ONLY: assert property (@(posedge pclk)
    disable iff (!presetn) !force_tog |=> !fifo_discard)
    else $error("FIFO discard without a force toggle write");

  AST_TOG_LOAD: assert property (@(posedge pclk)
    disable iff (!presetn)
      tog_write |=> data_toggle == $past(pwdata[BIT_TOGGLE]))
    else $error("Guarded toggle write did not load");

  AST_LINK_TOG: assert property (@(posedge pclk)
    disable iff (!presetn) (link_toggle_adv && !tog_write && !force_tog)
      |=> data_toggle != $past(data_toggle))
    else $error("Data toggle did not follow the link advance");

  AST_WR_RDATA: assert property (@(posedge pclk)
    disable iff (!presetn) (setup && pwrite) |=> prdata == 32'h00000000)
    else $error("Read data not cleared by a write");

  AST_UNMAPPED: assert property (@(posedge pclk)
    disable iff (!presetn) (setup && !hit_any) ##1 (psel && penable)
      |-> pslverr)
    else $error("Unmapped access answered without error");

  AST_MAPPED: assert property (@(posedge pclk)
    disable iff (!presetn) (setup && hit_any) ##1 (psel && penable)
      |-> !pslverr)
    else $error("Mapped access answered with error");

  COV_AUTO: cover property (@(posedge pclk) disable iff (!presetn)
    auto_set ##[1:20] pkt_sent);
  COV_FORCE: cover property (@(posedge pclk) disable iff (!presetn)
    force_tog && tx_packet_ready);
  COV_TOG_WR: cover property (@(posedge pclk) disable iff (!presetn)
    tog_write && pwdata[BIT_TOGGLE]);
  COV_IRQ_XFER: cover property (@(posedge pclk) disable iff (!presetn)
    dma_mode_reg && dma_irq);
  COV_DMA_PKT: cover property (@(posedge pclk) disable iff (!presetn)
    dma_en_reg && !dma_mode_reg && dma_irq);
endmodule : uhtx_ctrl_high

// ==== test/uhtx_link_model.sv ====
`timescale 1ns/1ps
// ==========================================================
// Far side of the link: sends each ready packet after dly
// ==========================================================
module uhtx_link_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       tx_packet_ready,
  input  wire logic [3:0] dly,
  input  wire logic       ack_en,
  output logic            pkt_sent,
  output logic            link_toggle_adv
);
  logic [3:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg         <= 4'h0;
      pkt_sent        <= 1'b0;
      link_toggle_adv <= 1'b0;
    end else begin
      pkt_sent        <= 1'b0;
      link_toggle_adv <= 1'b0;
      if (!pkt_sent && tx_packet_ready && cnt_reg == dly) begin
        // Without ack the toggle must stay put, as on a lost handshake
        pkt_sent        <= 1'b1;
        link_toggle_adv <= ack_en;
        cnt_reg         <= 4'h0;
      end else begin
        cnt_reg <= (tx_packet_ready && !pkt_sent) ? cnt_reg + 4'h1 : 4'h0;
      end
    end
  end
endmodule : uhtx_link_model

// ==== test/tb_usb_host_tx_endpoint_ctrl_high.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end
module tb_usb_host_tx_endpoint_ctrl_high;
  import uhtx_pkg::*;
  localparam logic [11:0] A_MPS = {IDX_MAX_PKT, 2'b00};
  localparam logic [11:0] A_LOW = {IDX_CTRL_LOW, 2'b00};
  localparam logic [11:0] A_HI  = {IDX_CTRL_HIGH, 2'b00};
  localparam logic [11:0] A_BAD = 12'h460;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err_seen, tog, ack_en = 1;
  logic        fifo_load = 0, fifo_shared = 0, fifo_has_room = 0;
  logic        dma_pkt_done = 0, dma_xfer_done = 0, pkt_sent, link_adv;
  logic        tx_packet_ready, dir_is_tx, dma_req, dma_irq, fifo_discard;
  logic        data_toggle;
  logic [3:0]  dly = 4'h8;
  logic [7:0]  w;
  logic [7:0]  corner [5] = '{8'h02, 8'h01, 8'h03, 8'h08, 8'h0B};
  int          err_count = 0, tests_run = 0;
  always #4 pclk = ~pclk;
  uhtx_ctrl_high dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fifo_load(fifo_load), .fifo_shared(fifo_shared),
    .fifo_has_room(fifo_has_room), .pkt_sent(pkt_sent),
    .link_toggle_adv(link_adv), .dma_pkt_done(dma_pkt_done),
    .dma_xfer_done(dma_xfer_done), .tx_packet_ready(tx_packet_ready),
    .dir_is_tx(dir_is_tx), .dma_req(dma_req), .dma_irq(dma_irq),
    .fifo_discard(fifo_discard), .data_toggle(data_toggle));
  uhtx_link_model link (.pclk(pclk), .presetn(presetn),
    .tx_packet_ready(tx_packet_ready), .dly(dly), .ack_en(ack_en),
    .pkt_sent(pkt_sent), .link_toggle_adv(link_adv));
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task loads(input int n);
    @(posedge pclk);
    fifo_load <= 1'b1;
    repeat (n) @(posedge pclk);
    fifo_load <= 1'b0;
    #1;
  endtask : loads
  task dma(input logic x);
    @(posedge pclk);
    dma_xfer_done <= x;
    dma_pkt_done  <= !x;
    @(posedge pclk);
    dma_xfer_done <= 1'b0;
    dma_pkt_done  <= 1'b0;
    #1;
  endtask : dma
  task wait_sent;
    for (int k = 0; k < 40 && tx_packet_ready; k++) @(posedge pclk) #1;
  endtask : wait_sent
  function logic nxt_tog(input logic [7:0] v, input logic t);
    return v[1] ? v[0] : (v[3] ? !t : t);
  endfunction : nxt_tog
  task end_sim;
    $display("mismatches %0d comparisons %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  initial begin
    #40000;
    err_count++;
    end_sim();
  end
  initial begin
    void'($urandom(32'hFFB7));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    tog = 1'b0;
    apb(0, A_HI, 0);
    `CHK("ctrl_high reset", {24'h0, CTRL_HIGH_RESET}, rd)
    apb(0, A_MPS, 0);
    `CHK("max size reset", {21'h0, MPS_RESET}, rd)
    for (int i = 0; i < 24; i++) begin
      w = (i < 5) ? corner[i] : 8'($urandom);
      w[BIT_DMA_MODE] = w[BIT_DMA_MODE] & ~w[BIT_DMA_EN];
      @(posedge pclk);
      fifo_shared   <= 1'($urandom);
      fifo_has_room <= 1'($urandom);
      apb(1, A_HI, {24'h0, w});
      #1 `CHK("discard", w[3], fifo_discard)
      tog = nxt_tog(w, tog);
      `CHK("toggle", tog, data_toggle)
      apb(0, A_HI, 0);
      `CHK("ctrl_high", {24'h0, w & 8'hB4 | {7'h0, tog}}, rd)
      `CHK("mapped error", 1'b0, err_seen)
      `CHK("direction", fifo_shared ? w[5] : 1'b1, dir_is_tx)
      `CHK("dma_req", w[4] & fifo_has_room, dma_req)
    end
    apb(1, A_MPS, 32'h4);
    apb(1, A_HI, 32'h80);
    loads(3);
    `CHK("ready early", 1'b0, tx_packet_ready)
    loads(1);
    `CHK("ready auto", 1'b1, tx_packet_ready)
    wait_sent();
    tog = !tog;
    `CHK("ready sent", 1'b0, tx_packet_ready)
    `CHK("toggle ack", tog, data_toggle)
    apb(1, A_HI, 32'h0);
    loads(4);
    `CHK("ready manual", 1'b0, tx_packet_ready)
    apb(1, A_LOW, 32'h1);
    #1 `CHK("ready sw", 1'b1, tx_packet_ready)
    apb(1, A_HI, 32'h08);
    #1 `CHK("ready force", 1'b0, tx_packet_ready)
    tog = !tog;
    `CHK("toggle force", tog, data_toggle)
    ack_en <= 1'b0;
    apb(1, A_LOW, 32'h1);
    wait_sent();
    `CHK("toggle no ack", tog, data_toggle)
    for (int m = 0; m < 4; m++) begin
      apb(1, A_HI, {27'h0, m[1], 1'b0, m[0], 2'b00});
      dma(1'b0);
      `CHK("irq packet", m[1] & !m[0], dma_irq)
      dma(1'b1);
      `CHK("irq transfer", m[1] & m[0], dma_irq)
    end
    apb(1, A_HI, 32'h04);
    apb(1, A_HI, 32'h00);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    tog = 1'b0;
    apb(0, A_HI, 0);
    `CHK("ctrl_high mid reset", {24'h0, CTRL_HIGH_RESET}, rd)
    `CHK("toggle mid reset", tog, data_toggle)
    apb(0, A_MPS, 0);
    `CHK("max size mid reset", {21'h0, MPS_RESET}, rd)
    apb(0, A_BAD, 0);
    `CHK("unmapped error", 1'b1, err_seen)
    `CHK("unmapped data", 32'h0, rd)
    end_sim();
  end
endmodule : tb_usb_host_tx_endpoint_ctrl_high
